// File: hw/frd_read_cmd.sv
// Purpose: Read Data command sequencer of the floppy controller
// Assumes: Disk bytes arrive framed by a data separator; all inputs synchronous
// Notes: Other transfer opcodes are answered as invalid with one status byte
// Overview of operation
// - All transfer commands share one nine-byte parameter and result layout.
// - With implied seek enabled, seek to the commanded cylinder first.
// - Drive busy bit stays high while the implied seek runs.
// - A failed seek reports abnormal status and the failing cylinder.
// - Load head if unloaded, wait settle time, then scan ID fields.
// - Matching sector address: read its data field into the FIFO.
// - After each sector, advance the sector number and read the next.
// - Terminal count or overrun stops transfer; sector still read and checked.
// - Size code selects 128 bytes shifted left by the code, up to 16K.
// - Size code zero with short length: send only that many bytes.
// - Writes pad a short 128-byte sector with zeros.
// - Nonzero size code: length byte is ignored for the count.
// - Multi-track reads continue from side 0 onto side 1.
// - Span per command follows size, end sector and multi-track.
// - Result ID after host termination depends on multi-track and end sector.
// - Head stays loaded for the unload interval after a command.
// - Two index pulses without the sector: abnormal, no-data, terminate.
// - CRC error: abnormal, data error, terminate; CRC flag in status 2 only for an ID field.
// - Skip clear: deleted mark read, control mark set, then stop.
// - Skip set: deleted sectors skipped with control mark, normal end.
// - Final sector at end sector: sector 1, then cylinder or head advance.
`timescale 1ns/10ps
`default_nettype none
module frd_read_cmd #(
  parameter int TICK_CYCLES = frd_pkg::TICK_CYC,
  parameter int FIFO_DEPTH  = frd_pkg::FIFO_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic [7:0]           cmd_byte,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  output logic                      cmd_active,
  output logic [7:0]                res_byte,
  output logic                      res_valid,
  input  wire logic                 res_ready,
  input  wire logic                 implied_seek_en,
  input  wire logic [7:0]           settle_ms,
  input  wire logic [7:0]           unload_ms,
  input  wire logic [7:0]           present_cyl,
  output logic                      seek_req,
  output logic [7:0]                seek_cyl,
  input  wire logic                 seek_done,
  input  wire logic                 seek_fail,
  input  wire logic [7:0]           seek_fail_cyl,
  output logic [3:0]                drive_busy,
  output logic                      head_load,
  output logic                      head_select,
  input  wire frd_pkg::frd_disk_type disk_in,
  input  wire logic                 index_pulse_n,
  input  wire logic                 terminal_count,
  output logic [7:0]                host_data,
  output logic                      host_valid,
  input  wire logic                 host_ready
);
  typedef struct packed {
    frd_pkg::frd_state_type st;
    logic [3:0]             ci;
    logic                   mt;
    logic                   sk;
    logic                   bad;
    logic                   del;
    logic                   stp;
    logic                   hds;
    logic                   hl;
    logic                   sreq;
    logic                   rdy;
    logic                   act;
    logic                   rv;
    logic                   pv;
    logic                   ixp;
    logic [1:0]             ds;
    logic [1:0]             ix;
    logic [3:0]             db;
    logic [2:0]             ri;
    frd_pkg::frd_id_type    cid;
    frd_pkg::frd_id_type    rid;
    logic [7:0]             end_of_track_sector;
    logic [7:0]             data_length;
    logic [7:0]             st0;
    logic [7:0]             st1;
    logic [7:0]             st2;
    logic [7:0]             ms;
    logic [7:0]             rb;
    logic [7:0]             pd;
    logic [14:0]            bc;
    logic [15:0]            crc;
    logic [15:0]            tk;
  } frd_main_type;

  frd_main_type        s_reg;
  frd_main_type        s_next;
  frd_pkg::frd_id_type nxt;
  logic                tick;
  logic                idx_edge;
  logic                at_eot;
  logic                eoc;
  logic                crc_ok;
  logic                fifo_rdy;
  logic [14:0]         size;
  logic [14:0]         xlen;
  logic [15:0]         crc_b;
  logic [15:0]         crc_am;

  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = {x[14:0], 1'b0} ^ ((x[15] ^ d[i]) ? frd_pkg::CRC_POLY : frd_pkg::CRC_RESID);
    end
    return x;
  endfunction

  // The separator hides the three sync bytes, so they are folded in here
  assign crc_am   = crc8(crc8(crc8(crc8(frd_pkg::CRC_INIT, frd_pkg::AM_SYNC), frd_pkg::AM_SYNC),
                         frd_pkg::AM_SYNC), disk_in.data);
  assign crc_b    = crc8(s_reg.crc, disk_in.data);
  assign crc_ok   = crc_b == frd_pkg::CRC_RESID;
  assign tick     = s_reg.tk == 16'(TICK_CYCLES - 1);
  assign idx_edge = s_reg.ixp & ~index_pulse_n;
  assign size     = frd_pkg::BASE_LEN << s_reg.cid.n[2:0];
  assign xlen     = (s_reg.cid.n == '0 && s_reg.data_length < frd_pkg::SHORT_MAX) ?
                    {7'h00, s_reg.data_length} : size;
  assign at_eot   = s_reg.cid.r == s_reg.end_of_track_sector;
  // Side 0 of a multi-track read rolls over to side 1 instead of ending
  assign eoc      = at_eot & ~(s_reg.mt & ~s_reg.cid.h[0]);

  always_comb begin
    nxt = s_reg.cid;
    if (at_eot) begin
      nxt.r = frd_pkg::SEC_FIRST;
      if (s_reg.mt && !s_reg.cid.h[0]) begin
        nxt.h[0] = 1'b1;
      end else begin
        nxt.c = s_reg.cid.c + 8'h01;
        if (s_reg.mt) begin
          nxt.h[0] = ~s_reg.cid.h[0];
        end
      end
    end else begin
      nxt.r = s_reg.cid.r + 8'h01;
    end
  end

  always_comb begin
    s_next      = s_reg;
    s_next.pv   = 1'b0;
    s_next.sreq = 1'b0;
    s_next.ixp  = index_pulse_n;
    s_next.tk   = tick ? '0 : s_reg.tk + 16'h0001;
    if (s_reg.st != frd_pkg::ST_RES) begin
      s_next.ri = '0;
    end
    if (s_reg.act && terminal_count) begin
      s_next.stp = 1'b1;
    end
    unique case (s_reg.st)
      frd_pkg::ST_CMD: begin
        if (s_reg.hl && tick) begin
          if (s_reg.ms == '0) begin
            s_next.hl = 1'b0;
          end else begin
            s_next.ms = s_reg.ms - 8'h01;
          end
        end
        if (cmd_valid && s_reg.rdy) begin
          s_next.ci = s_reg.ci + 4'h1;
          unique case (s_reg.ci)
            4'h0: begin
              s_next.mt  = cmd_byte[frd_pkg::MT_BIT];
              s_next.sk  = cmd_byte[frd_pkg::SK_BIT];
              s_next.bad = cmd_byte[frd_pkg::OP_HI:0] != frd_pkg::OP_READ;
              s_next.st0 = frd_pkg::ST0_BADCMD;
              s_next.st1 = '0;
              s_next.st2 = '0;
              s_next.stp = 1'b0;
              if (cmd_byte[frd_pkg::OP_HI:0] != frd_pkg::OP_READ) begin
                s_next.st = frd_pkg::ST_RES;
                s_next.ci = '0;
              end
            end
            4'h1: begin
              s_next.ds  = cmd_byte[1:0];
              s_next.hds = cmd_byte[frd_pkg::HDS_BIT];
            end
            4'h2: s_next.cid.c = cmd_byte;
            4'h3: s_next.cid.h = cmd_byte;
            4'h4: s_next.cid.r = cmd_byte;
            4'h5: s_next.cid.n = cmd_byte;
            4'h6: s_next.end_of_track_sector   = cmd_byte;
            4'h7: s_next.pd    = s_reg.pd;
            frd_pkg::CMD_LAST: begin
              s_next.data_length = cmd_byte;
              s_next.ci  = '0;
              s_next.act = 1'b1;
              s_next.st0 = {6'h00, s_reg.ds};
              s_next.st0[frd_pkg::ST0_HD] = s_reg.hds;
              if (implied_seek_en && s_reg.cid.c != present_cyl) begin
                s_next.st   = frd_pkg::ST_SEEK;
                s_next.sreq = 1'b1;
              end else begin
                s_next.st = frd_pkg::ST_SETTLE;
                s_next.ms = s_reg.hl ? '0 : settle_ms;
                s_next.hl = 1'b1;
              end
            end
            default: s_next.ci = '0;
          endcase
        end
      end
      frd_pkg::ST_SEEK: begin
        if (seek_done) begin
          if (seek_fail) begin
            s_next.st0[frd_pkg::IC_HI:frd_pkg::IC_LO] = frd_pkg::IC_ABN;
            s_next.st0[frd_pkg::ST0_SE] = 1'b1;
            s_next.cid.c = seek_fail_cyl;
            s_next.st    = frd_pkg::ST_RES;
          end else begin
            s_next.st = frd_pkg::ST_SETTLE;
            s_next.ms = s_reg.hl ? '0 : settle_ms;
            s_next.hl = 1'b1;
          end
        end
      end
      frd_pkg::ST_SETTLE: begin
        if (s_reg.ms == '0) begin
          s_next.st = frd_pkg::ST_FIND;
          s_next.ix = '0;
        end else if (tick) begin
          s_next.ms = s_reg.ms - 8'h01;
        end
      end
      frd_pkg::ST_FIND: begin
        if (idx_edge) begin
          s_next.ix = s_reg.ix + 2'h1;
          if (s_reg.ix == frd_pkg::IDX_LAST) begin
            s_next.st0[frd_pkg::IC_HI:frd_pkg::IC_LO] = frd_pkg::IC_ABN;
            s_next.st1[frd_pkg::ST1_ND] = 1'b1;
            s_next.st = frd_pkg::ST_RES;
          end
        end else if (disk_in.mark && disk_in.data == frd_pkg::AM_ID) begin
          s_next.st  = frd_pkg::ST_IDF;
          s_next.crc = crc_am;
          s_next.bc  = '0;
        end
      end
      frd_pkg::ST_IDF: begin
        if (disk_in.valid) begin
          s_next.crc = crc_b;
          s_next.bc  = s_reg.bc + 15'h0001;
          if (s_reg.bc < 15'h0004) begin
            s_next.rid = {s_reg.rid[23:0], disk_in.data};
          end
          if (s_reg.bc == frd_pkg::ID_LAST) begin
            if (!crc_ok) begin
              s_next.st0[frd_pkg::IC_HI:frd_pkg::IC_LO] = frd_pkg::IC_ABN;
              s_next.st1[frd_pkg::ST1_DE] = 1'b1;
              s_next.st2[frd_pkg::ST2_DD] = 1'b1;
              s_next.st = frd_pkg::ST_RES;
            end else if (s_reg.rid == s_reg.cid) begin
              s_next.st = frd_pkg::ST_DAM;
            end else begin
              s_next.st = frd_pkg::ST_FIND;
            end
          end
        end
      end
      frd_pkg::ST_DAM: begin
        if (disk_in.mark) begin
          if (disk_in.data == frd_pkg::AM_DATA || disk_in.data == frd_pkg::AM_DEL) begin
            s_next.del = disk_in.data == frd_pkg::AM_DEL;
            s_next.crc = crc_am;
            s_next.bc  = '0;
            s_next.st  = frd_pkg::ST_DATA;
          end else begin
            s_next.st = frd_pkg::ST_FIND;
          end
        end
      end
      frd_pkg::ST_DATA: begin
        // A full FIFO cannot stall the spinning disk, so it ends the transfer
        if (s_reg.pv && !fifo_rdy) begin
          s_next.stp = 1'b1;
        end
        if (disk_in.valid) begin
          s_next.crc = crc_b;
          s_next.bc  = s_reg.bc + 15'h0001;
          if (s_reg.bc < xlen && !s_next.stp && !(s_reg.sk && s_reg.del)) begin
            s_next.pv = 1'b1;
            s_next.pd = disk_in.data;
          end
          if (s_reg.bc == size + frd_pkg::CRC_TAIL) begin
            if (!crc_ok) begin
              s_next.st0[frd_pkg::IC_HI:frd_pkg::IC_LO] = frd_pkg::IC_ABN;
              s_next.st1[frd_pkg::ST1_DE] = 1'b1;
              s_next.st = frd_pkg::ST_RES;
            end else if (s_reg.del && !s_reg.sk) begin
              s_next.st2[frd_pkg::ST2_CM] = 1'b1;
              s_next.st = frd_pkg::ST_RES;
            end else begin
              s_next.st2[frd_pkg::ST2_CM] = s_reg.st2[frd_pkg::ST2_CM] | s_reg.del;
              s_next.cid = nxt;
              s_next.hds = nxt.h[0];
              if (s_next.stp || eoc) begin
                s_next.st = frd_pkg::ST_RES;
              end else begin
                s_next.st = frd_pkg::ST_FIND;
                s_next.ix = '0;
              end
            end
          end
        end
      end
      frd_pkg::ST_RES: begin
        if (res_ready) begin
          s_next.ri = s_reg.ri + 3'h1;
          if (s_reg.ri == frd_pkg::RES_LAST || s_reg.bad) begin
            s_next.st  = frd_pkg::ST_CMD;
            s_next.act = 1'b0;
            s_next.ms  = unload_ms;
          end
        end
      end
    endcase
    s_next.rdy = s_next.st == frd_pkg::ST_CMD;
    s_next.rv  = s_next.st == frd_pkg::ST_RES;
    s_next.db  = (s_next.st == frd_pkg::ST_SEEK) ? (4'h1 << s_next.ds) : 4'h0;
    unique case (s_next.ri)
      3'h0: s_next.rb = s_next.st0;
      3'h1: s_next.rb = s_next.st1;
      3'h2: s_next.rb = s_next.st2;
      3'h3: s_next.rb = s_next.cid.c;
      3'h4: s_next.rb = s_next.cid.h;
      3'h5: s_next.rb = s_next.cid.r;
      3'h6: s_next.rb = s_next.cid.n;
      default: s_next.rb = '0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg     <= '0;
      // Index pin idles high, so the edge detector starts there too
      s_reg.ixp <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  frd_fifo #(
    .WIDTH (frd_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (s_reg.pv),
    .in_data   (s_reg.pd),
    .in_ready  (fifo_rdy),
    .out_ready (host_ready),
    .out_valid (host_valid),
    .out_data  (host_data)
  );

  assign cmd_ready   = s_reg.rdy;
  assign cmd_active  = s_reg.act;
  assign res_byte    = s_reg.rb;
  assign res_valid   = s_reg.rv;
  assign seek_req    = s_reg.sreq;
  assign seek_cyl    = s_reg.cid.c;
  assign drive_busy  = s_reg.db;
  assign head_load   = s_reg.hl;
  assign head_select = s_reg.hds;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_seek_start:
    assert property ((s_reg.st == frd_pkg::ST_CMD && cmd_valid && s_reg.ci == frd_pkg::CMD_LAST
      && implied_seek_en && s_reg.cid.c != present_cyl) |=> seek_req && s_reg.st == frd_pkg::ST_SEEK)
    else $error("implied seek not started");
  a_busy_seek:
    assert property ((s_reg.st == frd_pkg::ST_SEEK && !seek_done) |=> drive_busy[$past(s_reg.ds)])
    else $error("drive busy low during seek");
  a_seek_fail:
    assert property ((s_reg.st == frd_pkg::ST_SEEK && seek_done && seek_fail) |=>
      s_reg.st0[frd_pkg::IC_HI:frd_pkg::IC_LO] == frd_pkg::IC_ABN && seek_cyl == $past(seek_fail_cyl))
    else $error("seek failure not reported");
  a_settle_wait:
    assert property ((s_reg.st == frd_pkg::ST_SETTLE && s_reg.ms != '0) |=>
      head_load && s_reg.st == frd_pkg::ST_SETTLE)
    else $error("scan began before settle time");
  a_push_src:
    assert property (s_reg.pv |-> $past(s_reg.st) == frd_pkg::ST_DATA && $past(disk_in.valid))
    else $error("host byte not from a data field");
  a_tc_stop:
    assert property ((s_reg.act && terminal_count) |=> !s_reg.pv [*3])
    else $error("data sent after terminal count");
  a_short_len:
    assert property ((s_reg.st == frd_pkg::ST_DATA && disk_in.valid && s_reg.bc >= xlen) |=> !s_reg.pv)
    else $error("byte sent beyond transfer length");
  a_no_sector:
    assert property ((s_reg.st == frd_pkg::ST_FIND && idx_edge && s_reg.ix == frd_pkg::IDX_LAST) |=>
      s_reg.st == frd_pkg::ST_RES && s_reg.st1[frd_pkg::ST1_ND])
    else $error("missing sector not reported");
  a_id_crc:
    assert property ((s_reg.st == frd_pkg::ST_IDF && disk_in.valid && s_reg.bc == frd_pkg::ID_LAST
      && !crc_ok) |=> s_reg.st1[frd_pkg::ST1_DE] && s_reg.st2[frd_pkg::ST2_DD])
    else $error("ID CRC error not reported");
  a_deleted_stop:
    assert property ((s_reg.st == frd_pkg::ST_DATA && disk_in.valid && crc_ok && s_reg.del && !s_reg.sk
      && s_reg.bc == size + frd_pkg::CRC_TAIL) |=> s_reg.st2[frd_pkg::ST2_CM] && $stable(s_reg.cid))
    else $error("deleted sector handling wrong");
  a_eot_wrap:
    assert property ((s_reg.st == frd_pkg::ST_DATA && disk_in.valid && crc_ok && !s_reg.del && at_eot
      && s_reg.bc == size + frd_pkg::CRC_TAIL) |=> s_reg.cid.r == frd_pkg::SEC_FIRST)
    else $error("sector did not wrap at end sector");
  a_res_first:
    assert property ((res_valid && s_reg.ri == '0) |-> res_byte == s_reg.st0)
    else $error("first result byte is not status 0");

  c_read_done: cover property (s_reg.st == frd_pkg::ST_RES && s_reg.ri == frd_pkg::RES_LAST && res_ready);
  c_seek: cover property (seek_req ##[1:200] seek_done);
  c_tc: cover property (s_reg.st == frd_pkg::ST_DATA && terminal_count);
  c_skip: cover property (s_reg.sk && s_reg.st2[frd_pkg::ST2_CM] && s_reg.st == frd_pkg::ST_FIND);
endmodule // frd_read_cmd
`default_nettype wire

// File: hw/frd_pkg.sv
// Purpose: Shared constants and types of the floppy Read Data sequencer
// Assumes: 25 MHz system clock
// Notes: Settle and unload intervals are counted in 1 ms units
package frd_pkg;
  localparam int CLK_HZ     = 25_000_000;
  localparam int CLK_NS     = 1_000_000_000 / CLK_HZ;
  localparam int TICK_NS    = 1_000_000;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W     = 8;

  localparam logic [4:0] OP_READ = 5'h06;
  localparam int OP_HI = 4, MT_BIT = 7, SK_BIT = 5, HDS_BIT = 2;
  localparam int IC_HI = 7, IC_LO = 6, ST0_SE = 5, ST0_HD = 2;
  localparam int ST1_DE = 5, ST1_ND = 2, ST2_CM = 6, ST2_DD = 5;

  localparam logic [1:0]  IC_OK = 2'h0, IC_ABN = 2'h1, IDX_LAST = 2'h1;
  localparam logic [7:0]  ST0_BADCMD = 8'h80, SEC_FIRST = 8'h01, SHORT_MAX = 8'h80;
  localparam logic [7:0]  AM_ID = 8'hfe, AM_DATA = 8'hfb, AM_DEL = 8'hf8, AM_SYNC = 8'ha1;
  localparam logic [14:0] BASE_LEN = 15'h0080, ID_LAST = 15'h0005, CRC_TAIL = 15'h0001;
  localparam logic [3:0]  CMD_LAST = 4'h8;
  localparam logic [2:0]  RES_LAST = 3'h6;
  localparam logic [15:0] CRC_INIT = 16'hffff, CRC_POLY = 16'h1021, CRC_RESID = 16'h0000;

  typedef enum logic [3:0] {
    ST_CMD    = 4'h0,
    ST_SEEK   = 4'h1,
    ST_SETTLE = 4'h2,
    ST_FIND   = 4'h3,
    ST_IDF    = 4'h4,
    ST_DAM    = 4'h5,
    ST_DATA   = 4'h6,
    ST_RES    = 4'h7
  } frd_state_type;

  typedef struct packed {
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
  } frd_id_type;

  typedef struct packed {
    logic       mark;
    logic       valid;
    logic [7:0] data;
  } frd_disk_type;
endpackage

// File: hw/frd_fifo.sv
// Purpose: Byte FIFO between the disk side and the host
// Assumes: Single clock, synchronous active-high reset
// Notes: Output is a registered stage, so out_data is held until taken
`timescale 1ns/10ps
`default_nettype none
module frd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  input  wire logic             out_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0]    wp;
    logic [AW-1:0]    rp;
    logic [AW:0]      cnt;
    logic             ov;
    logic [WIDTH-1:0] od;
  } frd_fifo_type;

  frd_fifo_type     s_reg;
  frd_fifo_type     s_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = s_reg.cnt < (AW+1)'(DEPTH);
  assign push      = in_valid & in_ready;
  assign pop       = (s_reg.cnt != '0) & (~s_reg.ov | out_ready);
  assign out_valid = s_reg.ov;
  assign out_data  = s_reg.od;

  always_comb begin
    s_next     = s_reg;
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      s_next.wp = (s_reg.wp == AW'(DEPTH - 1)) ? '0 : s_reg.wp + AW'(1);
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH - 1)) ? '0 : s_reg.rp + AW'(1);
      s_next.od = mem[s_reg.rp];
      s_next.ov = 1'b1;
    end else if (out_ready) begin
      s_next.ov = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
    if (push) begin
      mem[s_reg.wp] <= in_data;
    end
  end
endmodule // frd_fifo
`default_nettype wire

// File: dv/frd_drive_model.sv
// Purpose: Drive model: seek answer, index pulses, framed sector stream
// Assumes: One field byte every third clock
// Notes: Idle data toggles so a stale byte never reads as a fresh one
`timescale 1ns/10ps
`default_nettype none
module frd_drive_model (
  input  wire logic             clk_sys,
  input  wire logic             seek_req,
  output logic                  seek_done,
  output logic                  seek_fail,
  output logic [7:0]            seek_fail_cyl,
  output frd_pkg::frd_disk_type disk_in,
  output logic                  index_pulse_n
);
  logic        fail_v = 1'b0;
  logic [7:0]  fail_cyl = 8'h00;
  logic [15:0] crc;
  initial {seek_done, seek_fail, seek_fail_cyl, disk_in, index_pulse_n} = {11'h0, 9'h0, 1'b1};
  always @(posedge clk_sys) if (seek_req) begin
    repeat (4) @(posedge clk_sys);
    #1 {seek_done, seek_fail, seek_fail_cyl} = {1'b1, fail_v, fail_cyl};
    @(posedge clk_sys) #1 {seek_done, seek_fail, seek_fail_cyl} = {1'b0, ~fail_v, ~fail_cyl};
  end
  function automatic logic [15:0] upd(logic [15:0] c, logic [7:0] b);
    c ^= {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic put(input logic m, input logic [7:0] b);
    crc = upd(crc, b);
    @(posedge clk_sys) #1 disk_in = '{m, !m, b};
    repeat (2) @(posedge clk_sys) #1 disk_in = '{1'b0, 1'b0, ~disk_in.data};
  endtask
  task automatic field(input logic [7:0] am, input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    crc = 16'hffff;
    repeat (3) crc = upd(crc, 8'ha1);
    put(1'b1, am);
    foreach (q[i]) put(1'b0, q[i]);
    c = crc ^ {15'h0, bad};
    put(1'b0, c[15:8]);
    put(1'b0, c[7:0]);
  endtask
  task automatic sector(input logic [7:0] c, h, r, n, dm, input logic [1:0] bad);
    logic [7:0] q[$];
    repeat (30) @(posedge clk_sys);
    q = '{c, h, r, n};
    field(8'hfe, q, bad[1]);
    q.delete();
    for (int i = 0; i < (128 << n); i++) q.push_back(i[7:0] ^ 8'h5a);
    field(dm, q, bad[0]);
  endtask
  task automatic idx();
    @(posedge clk_sys) #1 index_pulse_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 index_pulse_n = 1'b1;
  endtask
endmodule // frd_drive_model
`default_nettype wire

// File: dv/floppy_read_data_command_tb.sv
// Purpose: Self-checking bench of the Read Data sequencer
// Assumes: One ms tick is shortened to four clocks
// Notes: Host takes bytes at random; expected bytes follow the model's pattern
`timescale 1ns/10ps
`default_nettype none
module floppy_read_data_command_tb;
  logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, res_ready = 1'b1, implied_seek_en = 1'b0;
  logic host_ready = 1'b1, terminal_count = 1'b0, cmd_ready, cmd_active, res_valid, seek_req, seek_done;
  logic seek_fail, head_load, head_select, host_valid, index_pulse_n;
  logic [7:0] cmd_byte = 8'h00, present_cyl = 8'h00, res_byte, seek_cyl, seek_fail_cyl, host_data, c, h, f;
  logic [3:0] drive_busy;
  logic [7:0] res_q[$];
  frd_pkg::frd_disk_type disk_in;
  int error_cnt = 0, total_checks = 0, host_cnt = 0, sz = 128, seed;
  always #20 clk_sys = ~clk_sys;
  frd_read_cmd #(.TICK_CYCLES(4), .FIFO_DEPTH(8)) dut_u (.clk_sys, .rst, .cmd_byte, .cmd_valid, .cmd_ready,
    .cmd_active, .res_byte, .res_valid, .res_ready, .implied_seek_en, .settle_ms(8'h02), .unload_ms(8'h10),
    .present_cyl, .seek_req, .seek_cyl, .seek_done, .seek_fail, .seek_fail_cyl, .drive_busy, .head_load,
    .head_select, .disk_in, .index_pulse_n, .terminal_count, .host_data, .host_valid, .host_ready);
  frd_drive_model drv_u (.clk_sys, .seek_req, .seek_done, .seek_fail, .seek_fail_cyl, .disk_in, .index_pulse_n);
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    if (res_valid && res_ready) res_q.push_back(res_byte);
    if (host_valid && host_ready) begin
      chk(host_data, 8'(host_cnt % sz) ^ 8'h5a);
      host_cnt++;
    end
    #1 host_ready = ($urandom % 4) != 0;
  end
  task automatic run(input logic [7:0] b0, r, n, end_of_track_sector, data_length);
    logic [7:0] b[9];
    int k = 0;
    b = '{b0, 8'h00, c, h, r, n, end_of_track_sector, 8'h1b, data_length};
    res_q.delete();
    host_cnt = 0;
    sz = 128 << n;
    for (int i = 0; i < 9; i++) begin
      cmd_byte = b[i];
      cmd_valid = 1'b1;
      do begin @(posedge clk_sys); k++; end while (!cmd_ready && k < 5000);
      #1;
      if (k >= 5000) begin error_cnt++; close_out(); end
      if (b0[4:0] != 5'h06) break;
    end
    cmd_valid = 1'b0;
  endtask
  task automatic res(input logic [7:0] e[7], input logic [6:0] m, input int n = 7);
    int k = 0;
    while (res_q.size() < n && k++ < 20000) @(posedge clk_sys);
    if (k > 20000) begin error_cnt++; close_out(); end
    repeat (20) @(posedge clk_sys);
    #1;
    for (int i = 0; i < n; i++) if (m[i]) chk(res_q[i], e[i]);
    $display("test ended at %0t", $time);
  endtask
  initial begin
    seed = $urandom(71);
    c = 8'($urandom);
    h = 8'($urandom);
    f = 8'($urandom);
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 run(8'h45, 8'h01, 8'h00, 8'h01, 8'hff);
    res('{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 7'h01, 1);
    run(8'h46, 8'h03, 8'h00, 8'h03, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, head_load}, 8'h01);
    drv_u.sector(c, h, 8'h03, 8'h00, 8'hfb, 1'b0);
    res('{8'h00, 8'h00, 8'h00, c + 8'h01, h, 8'h01, 8'h00}, 7'h7f);
    chk(8'(host_cnt), 8'h10);
    chk({7'h0, head_load}, 8'h01);
    run(8'h46, 8'h01, 8'h01, 8'h02, 8'hff);
    drv_u.sector(c, h, 8'h01, 8'h01, 8'hfb, 1'b0);
    drv_u.sector(c, h, 8'h02, 8'h01, 8'hfb, 1'b0);
    res('{8'h00, 8'h00, 8'h00, c + 8'h01, h, 8'h01, 8'h01}, 7'h7f);
    chk(8'(host_cnt / 16), 8'h20);
    run(8'h46, 8'h01, 8'h00, 8'h05, 8'hff);
    fork
      drv_u.sector(c, h, 8'h01, 8'h00, 8'hfb, 1'b0);
      begin repeat (250) @(posedge clk_sys); #1 terminal_count = 1'b1; end
    join
    res('{8'h00, 8'h00, 8'h00, c, h, 8'h02, 8'h00}, 7'h7f);
    chk({7'h0, host_cnt < 128}, 8'h01);
    terminal_count = 1'b0;
    run(8'h46, 8'h01, 8'h00, 8'h01, 8'hff);
    repeat (2) drv_u.idx();
    res('{8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 7'h03);
    run(8'h46, 8'h01, 8'h00, 8'h01, 8'hff);
    drv_u.sector(c, h, 8'h01, 8'h00, 8'hfb, 1'b1);
    res('{8'h40, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 7'h07);
    run(8'h46, 8'h02, 8'h00, 8'h04, 8'hff);
    drv_u.sector(c, h, 8'h02, 8'h00, 8'hf8, 1'b0);
    res('{8'h00, 8'h00, 8'h40, c, h, 8'h02, 8'h00}, 7'h3d);
    run(8'h66, 8'h01, 8'h00, 8'h02, 8'hff);
    drv_u.sector(c, h, 8'h01, 8'h00, 8'hf8, 1'b0);
    drv_u.sector(c, h, 8'h02, 8'h00, 8'hfb, 1'b0);
    res('{8'h00, 8'h00, 8'h40, c + 8'h01, h, 8'h01, 8'h00}, 7'h3d);
    chk(8'(host_cnt / 16), 8'h08);
    run(8'h46, 8'h01, 8'h00, 8'h01, 8'hff);
    drv_u.sector(c, h, 8'h01, 8'h00, 8'hfb, 2'h2);
    res('{8'h40, 8'h20, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00}, 7'h07);
    h[0] = 1'b0;
    run(8'h86, 8'h01, 8'h00, 8'h01, 8'hff);
    drv_u.sector(c, h, 8'h01, 8'h00, 8'hfb, 2'h0);
    drv_u.sector(c, h | 8'h01, 8'h01, 8'h00, 8'hfb, 2'h0);
    res('{8'h00, 8'h00, 8'h00, c + 8'h01, h, 8'h01, 8'h00}, 7'h7f);
    chk(8'(host_cnt / 16), 8'h10);
    {implied_seek_en, present_cyl, drv_u.fail_v, drv_u.fail_cyl} = {1'b1, c ^ 8'h01, 1'b1, f};
    run(8'h46, 8'h01, 8'h00, 8'h01, 8'hff);
    repeat (2) @(posedge clk_sys);
    chk({4'h0, drive_busy}, 8'h01);
    chk(seek_cyl, c);
    res('{8'h60, 8'h00, 8'h00, f, 8'h00, 8'h00, 8'h00}, 7'h09);
    close_out();
  end
endmodule // floppy_read_data_command_tb
`default_nettype wire
